// ==== hw/counter_array_compare_capture_module.sv ====
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccm_defs.svh"

module counter_array_compare_capture_module
    import ccm_pkg::*;
#(
    parameter bit watchdog_capable = 1'b1
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // shared counter, same clock
    input wire logic [7:0] counter_high,
    input wire logic [7:0] counter_low,
    // module pin
    input wire logic module_pin_in,
    output logic module_pin_out,
    output logic module_pin_oe,
    // events
    output logic irq,
    output logic watchdog_reset
);
    mode_ctrl_type mode_r, mode_nxt;
    status_type status_r, status_nxt, mask_r, mask_nxt, mask_eff;
    logic [7:0] cap_low_r, cap_low_nxt, cap_high_r, cap_high_nxt;
    logic [7:0] low_prev_r, low_prev_nxt;
    logic wdog_en_r, wdog_en_nxt, match_prev_r, match_prev_nxt;
    logic pin_out_r, pin_out_nxt, pin_oe_r, pin_oe_nxt;
    logic irq_r, irq_nxt, wdog_rst_r, wdog_rst_nxt;
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [7:0] awaddr_r, awaddr_nxt, wdata_r, wdata_nxt;
    logic wstrb0_r, wstrb0_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic pin_level, pin_rise, pin_fall;
    logic [15:0] count;
    logic pwm_mode, match_now, match_evt, cap_evt, rollover, wd_fire;
    logic wr_fire, wr_lane, wr_ok, sw_clear_flag;
    pin_sync u_pin_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(module_pin_in),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );
    assign count = {counter_high, counter_low};
    assign pwm_mode = mode_r.comparator_enable & mode_r.pulse_width_enable;
    assign match_now = (count == {cap_high_r, cap_low_r});
    // one event per match, not one per clock while the counter holds
    assign match_evt = mode_r.comparator_enable & ~mode_r.pulse_width_enable
                       & match_now & ~match_prev_r;
    assign cap_evt = (pin_rise & mode_r.capture_rise_enable)
                     | (pin_fall & mode_r.capture_fall_enable);
    assign rollover = (low_prev_r == `LOW_MAX) & (counter_low == `LOW_MIN);
    assign wd_fire = watchdog_capable & wdog_en_r & mode_r.match_flag_enable
                     & match_evt;
    assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_lane = wr_fire & wstrb0_r;
    assign sw_clear_flag = wr_lane & (awaddr_r == `OFS_STATUS) & wdata_r[0];
    assign mask_eff = {mask_r.wdog_event,
                       mask_r.module_event_flag & mode_r.module_irq_enable};
    always_comb
    begin
        mode_nxt = mode_r;
        cap_low_nxt = cap_low_r;
        cap_high_nxt = cap_high_r;
        status_nxt = status_r;
        mask_nxt = mask_r;
        wdog_en_nxt = wdog_en_r;
        match_prev_nxt = match_now;
        low_prev_nxt = counter_low;
        pin_out_nxt = pin_out_r;
        if (wr_lane)
        begin
            case (awaddr_r)
                `OFS_MODE: mode_nxt = mode_ctrl_type'(wdata_r & `MODE_USED_MASK);
                `OFS_CAP_LOW: cap_low_nxt = wdata_r;
                `OFS_CAP_HIGH: cap_high_nxt = wdata_r;
                `OFS_MASK: mask_nxt = status_type'(wdata_r[$bits(status_type)-1:0]);
                `OFS_WDOG: wdog_en_nxt = wdata_r[`WDOG_EN_BIT];
                `OFS_STATUS: status_nxt = status_r
                                          & ~status_type'(wdata_r[$bits(status_type)-1:0]);
                default: ;
            endcase
        end
        // hardware loads take priority over a software write to the same byte
        if (pwm_mode && rollover)
            cap_low_nxt = cap_high_r;
        if (cap_evt)
        begin
            cap_high_nxt = counter_high;
            cap_low_nxt = counter_low;
        end
        // set wins over a same-cycle clear
        if (cap_evt || (match_evt && mode_r.match_flag_enable))
            status_nxt.module_event_flag = 1'b1;
        if (wd_fire)
            status_nxt.wdog_event = 1'b1;
        if (pwm_mode)
            pin_out_nxt = (counter_low >= cap_low_r);
        else if (match_evt && mode_r.match_toggle_enable && mode_r.match_flag_enable)
            pin_out_nxt = ~pin_out_r;
        pin_oe_nxt = pwm_mode | (mode_r.comparator_enable & mode_r.match_toggle_enable);
        irq_nxt = |(status_r & mask_eff);
        wdog_rst_nxt = wd_fire;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_r <= mode_ctrl_type'(`RST_BYTE);
            cap_low_r <= `RST_BYTE;
            cap_high_r <= `RST_BYTE;
            status_r <= status_type'(`RST_BYTE);
            mask_r <= status_type'(`RST_BYTE);
            wdog_en_r <= `RST_BIT;
            match_prev_r <= `RST_BIT;
            low_prev_r <= `RST_BYTE;
            pin_out_r <= `RST_BIT;
            pin_oe_r <= `RST_BIT;
            irq_r <= `RST_BIT;
            wdog_rst_r <= `RST_BIT;
        end
        else
        begin
            mode_r <= mode_nxt;
            cap_low_r <= cap_low_nxt;
            cap_high_r <= cap_high_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            wdog_en_r <= wdog_en_nxt;
            match_prev_r <= match_prev_nxt;
            low_prev_r <= low_prev_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            irq_r <= irq_nxt;
            wdog_rst_r <= wdog_rst_nxt;
        end
    end
    // axi4-lite slave: address and data taken in either order, one of each held
    always_comb
    begin
        aw_have_nxt = aw_have_r;
        w_have_nxt = w_have_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb0_nxt = wstrb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        wr_ok = (awaddr_r == `OFS_MODE) || (awaddr_r == `OFS_CAP_LOW)
                || (awaddr_r == `OFS_CAP_HIGH) || (awaddr_r == `OFS_STATUS)
                || (awaddr_r == `OFS_MASK) || (awaddr_r == `OFS_WDOG)
                || (awaddr_r == `OFS_PIN);
        if (awvalid && awready_r)
        begin
            aw_have_nxt = 1'b1;
            awaddr_nxt = awaddr;
        end
        if (wvalid && wready_r)
        begin
            w_have_nxt = 1'b1;
            wdata_nxt = wdata[7:0];
            wstrb0_nxt = wstrb[0];
        end
        if (wr_fire)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid_r && bready)
            bvalid_nxt = 1'b0;
        if (arvalid && arready_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `RESP_OKAY;
            case (araddr)
                `OFS_MODE: rdata_nxt = 32'(mode_r);
                `OFS_CAP_LOW: rdata_nxt = 32'(cap_low_r);
                `OFS_CAP_HIGH: rdata_nxt = 32'(cap_high_r);
                `OFS_STATUS: rdata_nxt = 32'(status_r);
                `OFS_MASK: rdata_nxt = 32'(mask_r);
                `OFS_WDOG: rdata_nxt = 32'(wdog_en_r);
                `OFS_PIN: rdata_nxt = 32'({pin_out_r, pin_level});
                default:
                begin
                    rdata_nxt = 32'(`RST_BYTE);
                    rresp_nxt = `RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_r && rready)
            rvalid_nxt = 1'b0;
        awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
        wready_nxt = ~w_have_nxt & ~bvalid_nxt;
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= `RST_BIT;
            w_have_r <= `RST_BIT;
            awaddr_r <= `RST_BYTE;
            wdata_r <= `RST_BYTE;
            wstrb0_r <= `RST_BIT;
            awready_r <= `RST_READY;
            wready_r <= `RST_READY;
            bvalid_r <= `RST_BIT;
            bresp_r <= `RESP_OKAY;
            arready_r <= `RST_READY;
            rvalid_r <= `RST_BIT;
            rdata_r <= 32'(`RST_BYTE);
            rresp_r <= `RESP_OKAY;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb0_r <= wstrb0_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign module_pin_out = pin_out_r;
    assign module_pin_oe = pin_oe_r;
    assign irq = irq_r;
    assign watchdog_reset = wdog_rst_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rise_capture_a: assert property (
        pin_rise && mode_r.capture_rise_enable |=> status_r.module_event_flag)
        else $error("rising edge capture did not set the event flag");
    capture_value_a: assert property (
        cap_evt |=> {cap_high_r, cap_low_r} == $past(count))
        else $error("capture did not copy the counter");
    irq_gate_a: assert property (
        irq_r |-> $past((status_r.module_event_flag & mode_r.module_irq_enable
                         & mask_r.module_event_flag)
                        | (status_r.wdog_event & mask_r.wdog_event)))
        else $error("interrupt raised without an enabled flag");
    match_flag_a: assert property (
        match_evt && mode_r.match_flag_enable |=> status_r.module_event_flag)
        else $error("match did not set the event flag");
    match_toggle_a: assert property (
        match_evt && mode_r.match_toggle_enable && mode_r.match_flag_enable
        |=> module_pin_out != $past(module_pin_out))
        else $error("pin did not toggle on match");
    pwm_level_a: assert property (
        pwm_mode |=> module_pin_out == ($past(counter_low) >= $past(cap_low_r)))
        else $error("pulse width output level wrong");
    pwm_reload_a: assert property (
        pwm_mode && rollover && !cap_evt |=> cap_low_r == $past(cap_high_r))
        else $error("compare low not reloaded on wrap");
    wdog_pulse_a: assert property (
        wd_fire |=> watchdog_reset ##1 !watchdog_reset)
        else $error("watchdog reset not a single pulse");
    wdog_disable_a: assert property (
        !wdog_en_r |=> !watchdog_reset)
        else $error("watchdog reset while disabled");
    flag_sticky_a: assert property (
        status_r.module_event_flag && !sw_clear_flag |=> status_r.module_event_flag)
        else $error("event flag lost without a software clear");

    capture_seen_c: cover property (cap_evt ##1 status_r.module_event_flag);
    toggle_seen_c: cover property (match_evt && mode_r.match_toggle_enable);
    reload_seen_c: cover property (pwm_mode && rollover);
    wdog_seen_c: cover property (watchdog_reset);

endmodule // counter_array_compare_capture_module

`default_nettype wire

// ==== hw/ccm_defs.svh ====
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

// register byte offsets on the axi4-lite slave
`define OFS_MODE 8'h00
`define OFS_CAP_LOW 8'h04
`define OFS_CAP_HIGH 8'h08
`define OFS_STATUS 8'h0c
`define OFS_MASK 8'h10
`define OFS_WDOG 8'h14
`define OFS_PIN 8'h18

// reset values
`define RST_BYTE 8'h00
`define RST_BIT 1'b0
`define RST_READY 1'b1

// field layout
`define MODE_USED_MASK 8'h7f
`define WDOG_EN_BIT 0

// counter low byte wrap points
`define LOW_MAX 8'hff
`define LOW_MIN 8'h00

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hw/ccm_pkg.sv ====
package ccm_pkg;

    // module mode control byte, msb reserved
    typedef struct packed {
        logic reserved;
        logic comparator_enable;
        logic capture_rise_enable;
        logic capture_fall_enable;
        logic match_flag_enable;
        logic match_toggle_enable;
        logic pulse_width_enable;
        logic module_irq_enable;
    } mode_ctrl_type;

    // sticky event bits, also the layout of the mask
    typedef struct packed {
        logic wdog_event;
        logic module_event_flag;
    } status_type;

endpackage : ccm_pkg

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccm_defs.svh"

module pin_sync
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // raw pin
    input wire logic pin_in,
    // filtered level and edges
    output logic level,
    output logic rise,
    output logic fall
);

    logic s1_r, s2_r, s3_r, level_r, rise_r, fall_r;
    logic level_nxt, rise_nxt, fall_nxt;

    always_comb
    begin
        // a change counts once the second and third stages agree
        level_nxt = (s2_r == s3_r) ? s3_r : level_r;
        rise_nxt = level_nxt & ~level_r;
        fall_nxt = ~level_nxt & level_r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_r <= `RST_BIT;
            s2_r <= `RST_BIT;
            s3_r <= `RST_BIT;
            level_r <= `RST_BIT;
            rise_r <= `RST_BIT;
            fall_r <= `RST_BIT;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign level = level_r;
    assign rise = rise_r;
    assign fall = fall_r;

endmodule // pin_sync

`default_nettype wire

// ==== sim/pin_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_partner
(
    // level the far side wants on the pin
    input wire logic level_cmd,
    // block side of the pin
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    logic src = 1'b0;

    // far side source moves with a skew unrelated to the clock
    always @(level_cmd)
    begin
        src <= #7 level_cmd;
    end

    // while the block drives, the wire carries its level
    assign pin_in = pin_oe ? pin_out : src;
endmodule // pin_partner

`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccm_defs.svh"

module testbench;
    import ccm_pkg::*;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pin_in, irq, wd_reset;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] cnt = 16'h0000;
    logic pin_level = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    int wd_pulses = 0;
    logic [33:0] exp_q[$];

    always #12.5 aclk = ~aclk;

    counter_array_compare_capture_module #(.watchdog_capable(1'b1))
    counter_array_compare_capture_module_i
    (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .counter_high(cnt[15:8]), .counter_low(cnt[7:0]),
        .module_pin_in(pin_in), .module_pin_out(pin_out), .module_pin_oe(pin_oe),
        .irq(irq), .watchdog_reset(wd_reset)
    );

    pin_partner pin_partner_i
    (
        .level_cmd(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in)
    );

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                chk("bresp", {30'h0, bresp}, {30'h0, `RESP_OKAY});
                break;
            end
        end
    endtask

    // the expected answer is queued; the read monitor compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        exp_q.push_back({r, e});
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
    endtask

    always @(posedge aclk)
    begin
        if (rvalid === 1'b1 && rready)
        begin
            logic [33:0] e;
            e = exp_q.pop_front();
            chk("rdata", rdata, e[31:0]);
            chk("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
        end
        if (wd_reset === 1'b1)
            wd_pulses++;
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        end_sim();
    end

    initial
    begin
        logic [7:0] modes[3] = '{8'h20, 8'h10, 8'h30};
        logic [7:0] ofs[6] = '{`OFS_MODE, `OFS_CAP_LOW, `OFS_CAP_HIGH, `OFS_STATUS,
                               `OFS_MASK, `OFS_WDOG};
        logic [15:0] v;
        logic [15:0] cap;
        logic cap_hit;
        logic prev;
        int base;
        void'($urandom(32'had5fe40e));
        cap = 16'h0000;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (ofs[i])
            rd(ofs[i], 32'h0, `RESP_OKAY);
        rd(8'h1c, 32'h0, `RESP_SLVERR);
        wr(`OFS_MODE, 32'h80);
        rd(`OFS_MODE, 32'h0, `RESP_OKAY);
        // each edge setting against a rising then a falling pin
        foreach (modes[m])
        begin
            wr(`OFS_MODE, {24'h0, modes[m]});
            for (int e = 0; e < 2; e++)
            begin
                v = 16'($urandom);
                cnt <= v;
                pin_level <= (e == 0);
                repeat (10) @(posedge aclk);
                cap_hit = (e == 0) ? modes[m][5] : modes[m][4];
                if (cap_hit)
                    cap = v;
                rd(`OFS_CAP_LOW, {24'h0, cap[7:0]}, `RESP_OKAY);
                rd(`OFS_CAP_HIGH, {24'h0, cap[15:8]}, `RESP_OKAY);
                rd(`OFS_STATUS, {31'h0, cap_hit}, `RESP_OKAY);
                wr(`OFS_STATUS, 32'h1);
                rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
            end
        end
        // software timer with and without interrupt enable
        v = 16'($urandom);
        cnt <= v + 16'h1;
        wr(`OFS_MASK, 32'h1);
        wr(`OFS_CAP_LOW, {24'h0, v[7:0]});
        wr(`OFS_CAP_HIGH, {24'h0, v[15:8]});
        wr(`OFS_MODE, 32'h49);
        rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
        cnt <= v;
        repeat (4) @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h1);
        cnt <= v + 16'h1;
        rd(`OFS_STATUS, 32'h1, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h1);
        @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(`OFS_MODE, 32'h48);
        cnt <= v;
        repeat (4) @(posedge aclk);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(`OFS_STATUS, 32'h1, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h1);
        // high speed output: every match inverts the pin
        cnt <= v + 16'h1;
        wr(`OFS_MODE, 32'h4c);
        repeat (2)
        begin
            repeat (3) @(posedge aclk);
            prev = pin_out;
            cnt <= v;
            repeat (3) @(posedge aclk);
            cnt <= v + 16'h1;
            chk("pin_out", {31'h0, pin_out}, {31'h0, ~prev});
            chk("pin_oe", {31'h0, pin_oe}, 32'h1);
        end
        // the matches above left the sticky flag set
        rd(`OFS_STATUS, 32'h1, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h1);
        // pulse width with reload at the low byte wrap
        cnt <= 16'h007f;
        wr(`OFS_CAP_LOW, 32'h80);
        wr(`OFS_CAP_HIGH, 32'h40);
        wr(`OFS_MODE, 32'h42);
        repeat (3) @(posedge aclk);
        chk("pin_out", {31'h0, pin_out}, 32'h0);
        cnt <= 16'h0080;
        repeat (3) @(posedge aclk);
        chk("pin_out", {31'h0, pin_out}, 32'h1);
        cnt <= 16'h00ff;
        repeat (2) @(posedge aclk);
        cnt <= 16'h0100;
        repeat (3) @(posedge aclk);
        rd(`OFS_CAP_LOW, 32'h40, `RESP_OKAY);
        cnt <= 16'h013f;
        repeat (3) @(posedge aclk);
        chk("pin_out", {31'h0, pin_out}, 32'h0);
        cnt <= 16'h0140;
        repeat (3) @(posedge aclk);
        chk("pin_out", {31'h0, pin_out}, 32'h1);
        rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
        rd(`OFS_PIN, 32'h3, `RESP_OKAY);
        // watchdog armed, disabled, then re-armed
        v = 16'($urandom);
        cnt <= v + 16'h1;
        wr(`OFS_MODE, 32'h48);
        wr(`OFS_CAP_LOW, {24'h0, v[7:0]});
        wr(`OFS_CAP_HIGH, {24'h0, v[15:8]});
        wr(`OFS_WDOG, 32'h1);
        base = wd_pulses;
        cnt <= v;
        repeat (4) @(posedge aclk);
        chk("wd_pulses", 32'(wd_pulses - base), 32'h1);
        rd(`OFS_STATUS, 32'h3, `RESP_OKAY);
        wr(`OFS_STATUS, 32'h3);
        cnt <= v + 16'h1;
        // service from main-line code: move the compare value away from the counter
        wr(`OFS_CAP_LOW, {24'h0, v[7:0] ^ 8'h80});
        cnt <= v;
        repeat (4) @(posedge aclk);
        chk("wd_pulses", 32'(wd_pulses - base), 32'h1);
        cnt <= v + 16'h1;
        wr(`OFS_CAP_LOW, {24'h0, v[7:0]});
        wr(`OFS_WDOG, 32'h0);
        cnt <= v;
        repeat (4) @(posedge aclk);
        chk("wd_pulses", 32'(wd_pulses - base), 32'h1);
        rd(`OFS_STATUS, 32'h1, `RESP_OKAY);
        cnt <= v + 16'h1;
        wr(`OFS_WDOG, 32'h1);
        cnt <= v;
        repeat (4) @(posedge aclk);
        chk("wd_pulses", 32'(wd_pulses - base), 32'h2);
        end_sim();
    end
endmodule // testbench

`default_nettype wire
